// ===== src/fmul_pkg.sv
package fmul_pkg;

  // Operand formats
  localparam int unsigned SP_EXP_W = 8;
  localparam int unsigned SP_MAN_W = 23;
  localparam int unsigned DP_EXP_W = 11;
  localparam int unsigned DP_MAN_W = 52;

  // Issue kinds from dispatch
  typedef enum logic [1:0] {
    KIND_FP64 = 2'h0,
    KIND_FP32 = 2'h1,
    KIND_INT  = 2'h2
  } mul_kind_t;

  // Occupancy of the multiply unit
  typedef enum logic [1:0] {
    RUN_NONE     = 2'h0,
    RUN_FP64     = 2'h1,
    RUN_INT_LOW  = 2'h2,
    RUN_INT_WIDE = 2'h3
  } run_t;

  // Integer operation fields
  localparam logic [4:0] OPF_LOW_REG  = 5'h04;
  localparam logic [4:0] OPF_LOW_CST  = 5'h06;
  localparam logic [4:0] OPF_WIDE_REG = 5'h08;
  localparam logic [4:0] OPF_WIDE_CST = 5'h0C;

  // Pipeline stages (E1 = issue cycle)
  localparam int unsigned OCC_STAGES = 4;
  localparam int unsigned E_SP_CAP   = 1;
  localparam int unsigned E_SP_WR    = 4;
  localparam int unsigned E_DP_CAP   = 4;
  localparam int unsigned E_DP_LO_WR = 9;
  localparam int unsigned E_DP_HI_WR = 10;
  localparam int unsigned E_IL_CAP   = 4;
  localparam int unsigned E_IL_WR    = 9;
  localparam int unsigned E_IW_CAP   = 3;
  localparam int unsigned E_IW_LO_WR = 9;
  localparam int unsigned E_IW_HI_WR = 10;

  // Exception flag positions
  localparam int unsigned FLAG_W          = 4;
  localparam int unsigned FLAG_INVALID_OP = 0;
  localparam int unsigned FLAG_INEXACT    = 1;
  localparam int unsigned FLAG_DNRM_SRC1  = 2;
  localparam int unsigned FLAG_DNRM_SRC2  = 3;

  // Register port
  localparam int unsigned REG_AW     = 4;
  localparam logic [3:0]  REG_STATUS = 4'h0;
  localparam logic [3:0]  REG_MASK   = 4'h4;
  localparam logic [3:0]  REG_STATE  = 4'h8;
  localparam logic [3:0]  STATUS_RST = 4'h0;
  localparam logic [3:0]  MASK_RST   = 4'h0;

  // Integer field decoding, used at issue and during the run
  function automatic logic opf_legal(input logic [4:0] opf);
    return (opf == OPF_LOW_REG) || (opf == OPF_LOW_CST) ||
           (opf == OPF_WIDE_REG) || (opf == OPF_WIDE_CST);
  endfunction

  function automatic logic opf_wide(input logic [4:0] opf);
    return (opf == OPF_WIDE_REG) || (opf == OPF_WIDE_CST);
  endfunction

  function automatic logic opf_cst(input logic [4:0] opf);
    return (opf == OPF_LOW_CST) || (opf == OPF_WIDE_CST);
  endfunction

endpackage

// ===== src/fp_mul_core.sv
`timescale 1ns/1ps
module fp_mul_core #(
  parameter int unsigned EXP_W = 8,
  parameter int unsigned MAN_W = 23
) (
  // Operands
  input  wire logic [EXP_W+MAN_W:0]            a_i,
  input  wire logic [EXP_W+MAN_W:0]            b_i,
  // Product and exceptions
  output logic      [EXP_W+MAN_W:0]            res_o,
  output logic      [fmul_pkg::FLAG_W-1:0]     flags_o
);
  import fmul_pkg::*;

  localparam int unsigned PW = 2 * (MAN_W + 1);
  localparam int unsigned EW = EXP_W + 2;
  localparam logic signed [EW-1:0] BIAS = EW'((2 ** (EXP_W - 1)) - 1);
  localparam logic signed [EW-1:0] EMAX = EW'((2 ** EXP_W) - 1);
  // Class vector positions
  localparam int unsigned C_NAN  = 0;
  localparam int unsigned C_SNAN = 1;
  localparam int unsigned C_INF  = 2;
  localparam int unsigned C_ZERO = 3;
  localparam int unsigned C_DEN  = 4;

  // Guard and sticky bits need at least two fraction bits
  if (EXP_W < 2 || MAN_W < 2)
  begin : g_param_check
    $error("fp_mul_core needs EXP_W and MAN_W of at least 2");
  end

  // Zero class covers denormals, which are flushed
  function automatic logic [4:0] classify(input logic [EXP_W+MAN_W:0] x);
    logic ones;
    logic nil;
    logic frac;
    ones = &x[EXP_W+MAN_W-1:MAN_W];
    nil  = ~|x[EXP_W+MAN_W-1:MAN_W];
    frac = |x[MAN_W-1:0];
    classify = {nil & frac, nil, ones & ~frac, ones & frac & ~x[MAN_W-1], ones & frac};
  endfunction

  logic [4:0]              ca;
  logic [4:0]              cb;
  logic                    sign;
  logic [PW-1:0]           prod;
  logic [PW-1:0]           norm;
  logic [MAN_W:0]          keep;
  logic                    guard;
  logic                    sticky;
  logic                    rnd_up;
  logic [MAN_W+1:0]        rounded;
  logic signed [EW-1:0]    exp_s;

  // Mantissa product, normalised and rounded to nearest even
  assign ca      = classify(a_i);
  assign cb      = classify(b_i);
  assign sign    = a_i[EXP_W+MAN_W] ^ b_i[EXP_W+MAN_W];
  assign prod    = PW'({1'b1, a_i[MAN_W-1:0]}) * PW'({1'b1, b_i[MAN_W-1:0]});
  assign norm    = prod[PW-1] ? prod : {prod[PW-2:0], 1'b0};
  assign keep    = norm[PW-1 -: MAN_W+1];
  assign guard   = norm[PW-MAN_W-2];
  assign sticky  = |norm[PW-MAN_W-3:0];
  assign rnd_up  = guard & (sticky | keep[0]);
  assign rounded = {1'b0, keep} + (MAN_W+2)'(rnd_up);
  assign exp_s   = EW'({2'b00, a_i[EXP_W+MAN_W-1:MAN_W]}) + EW'({2'b00, b_i[EXP_W+MAN_W-1:MAN_W]})
                 - BIAS + EW'(prod[PW-1]) + EW'(rounded[MAN_W+1]);

  // Special operands take priority over the arithmetic result
  always_comb
  begin
    res_o                = {sign, exp_s[EXP_W-1:0], rounded[MAN_W-1:0]};
    flags_o              = '0;
    flags_o[FLAG_DNRM_SRC1] = ca[C_DEN];
    flags_o[FLAG_DNRM_SRC2] = cb[C_DEN];
    if (ca[C_NAN] | cb[C_NAN])
    begin
      res_o              = {sign, {EXP_W{1'b1}}, {MAN_W{1'b1}}};
      flags_o[FLAG_INVALID_OP] = ca[C_SNAN] | cb[C_SNAN];
    end
    else if ((ca[C_INF] & cb[C_ZERO]) | (cb[C_INF] & ca[C_ZERO]))
    begin
      res_o              = {sign, {EXP_W{1'b1}}, {MAN_W{1'b1}}};
      flags_o[FLAG_INVALID_OP] = 1'b1;
    end
    else if (ca[C_INF] | cb[C_INF])
    begin
      res_o              = {sign, {EXP_W{1'b1}}, {MAN_W{1'b0}}};
    end
    else if (ca[C_ZERO] | cb[C_ZERO])
    begin
      res_o              = {sign, {(EXP_W+MAN_W){1'b0}}};
      flags_o[FLAG_INEXACT] = (ca[C_DEN] & ~cb[C_ZERO]) | (cb[C_DEN] & ~ca[C_ZERO]);
    end
    else if (exp_s >= EMAX)
    begin
      // Overflow saturates to infinity; no overflow flag kept here
      res_o              = {sign, {EXP_W{1'b1}}, {MAN_W{1'b0}}};
      flags_o[FLAG_INEXACT] = 1'b1;
    end
    else if (exp_s <= 0)
    begin
      // Tiny results flush to zero, matching the denormal input policy
      res_o              = {sign, {(EXP_W+MAN_W){1'b0}}};
      flags_o[FLAG_INEXACT] = 1'b1;
    end
    else
    begin
      flags_o[FLAG_INEXACT] = guard | sticky;
    end
  end

endmodule

// ===== src/fp_int_multiply_unit.sv
`timescale 1ns/1ps
module fp_int_multiply_unit #(
  parameter int unsigned DATA_W = 32
) (
  // Clock and reset
  input  wire logic                            core_clk_i,
  input  wire logic                            rstn_i,
  // Issue from dispatch
  input  wire logic                            issue_valid_i,
  input  wire logic                            issue_cond_i,
  input  wire fmul_pkg::mul_kind_t             issue_kind_i,
  input  wire logic [4:0]                      issue_opfield_i,
  input  wire logic [4:0]                      issue_cst_i,
  output logic                                 issue_ready_o,
  // Operand read ports
  input  wire logic [DATA_W-1:0]               src1_i,
  input  wire logic [DATA_W-1:0]               src2_i,
  output logic                                 src1_hi_o,
  output logic                                 src2_hi_o,
  // Register file write-back
  output logic                                 wr_valid_o,
  output logic                                 wr_odd_o,
  output logic [DATA_W-1:0]                    wr_data_o,
  output logic [fmul_pkg::FLAG_W-1:0]          wr_flags_o,
  // Register port
  input  wire logic [fmul_pkg::REG_AW-1:0]     reg_addr_i,
  input  wire logic [31:0]                     reg_wdata_i,
  input  wire logic                            reg_wr_i,
  input  wire logic                            reg_rd_i,
  output logic [31:0]                          reg_rdata_o,
  // Interrupt
  output logic                                 irq_o
);
  import fmul_pkg::*;

  // Write slots in the delay line, from capture stage to write stage
  localparam int unsigned SLOT_SP    = E_SP_WR - E_SP_CAP - 2;
  localparam int unsigned SLOT_DP_LO = E_DP_LO_WR - E_DP_CAP - 2;
  localparam int unsigned SLOT_DP_HI = E_DP_HI_WR - E_DP_CAP - 2;
  localparam int unsigned SLOT_IL    = E_IL_WR - E_IL_CAP - 2;
  localparam int unsigned SLOT_IW_LO = E_IW_LO_WR - E_IW_CAP - 2;
  localparam int unsigned SLOT_IW_HI = E_IW_HI_WR - E_IW_CAP - 2;
  localparam int unsigned LINE_D     = SLOT_IW_HI + 1;
  localparam logic [1:0]  LAST_STG   = 2'(OCC_STAGES - 1);
  localparam logic [1:0]  IW_STG     = 2'(E_IW_CAP - 1);

  // The datapath is built around 32-bit words and register pairs
  if (DATA_W != 32)
  begin : g_width_check
    $error("fp_int_multiply_unit supports DATA_W = 32 only");
  end

  // Occupancy state
  run_t                    run_q;
  run_t                    run_d;
  logic [1:0]              stage_q;
  logic [4:0]              opf_q;
  logic [4:0]              cst_q;
  logic [DATA_W-1:0]       a_lo_q;
  logic [DATA_W-1:0]       b_lo_q;

  // Issue and completion events
  logic                    accept;
  logic                    fire_sp;
  logic                    dp_done;
  logic                    il_done;
  logic                    iw_done;
  logic [4:0]              opf_now;
  logic [4:0]              cst_now;

  // Datapath results
  logic [DATA_W-1:0]       sp_res;
  logic [FLAG_W-1:0]       sp_flags;
  logic [2*DATA_W-1:0]     dp_res;
  logic [FLAG_W-1:0]       dp_flags;
  logic [DATA_W-1:0]       int_a;
  logic signed [2*DATA_W-1:0] int_prod;

  // Delay line toward the register file
  logic [LINE_D-1:0]       line_v_q;
  logic [LINE_D-1:0]       line_odd_q;
  logic [DATA_W-1:0]       line_data_q  [LINE_D];
  logic [FLAG_W-1:0]       line_flags_q [LINE_D];
  logic [LINE_D-1:0]       ins_v;
  logic [LINE_D-1:0]       ins_odd;
  logic [DATA_W-1:0]       ins_data  [LINE_D];
  logic [FLAG_W-1:0]       ins_flags [LINE_D];

  // Software registers
  logic [FLAG_W-1:0]       status_q;
  logic [FLAG_W-1:0]       status_d;
  logic [FLAG_W-1:0]       mask_q;
  logic [FLAG_W-1:0]       mask_d;

  // A false predicate makes the issue a no-operation
  assign accept  = issue_valid_i & issue_ready_o & issue_cond_i &
                   ((issue_kind_i == KIND_FP64) || (issue_kind_i == KIND_FP32) ||
                    ((issue_kind_i == KIND_INT) && opf_legal(issue_opfield_i)));
  assign fire_sp = accept & (issue_kind_i == KIND_FP32);
  assign dp_done = (run_q == RUN_FP64) & (stage_q == LAST_STG);
  assign il_done = (run_q == RUN_INT_LOW) & (stage_q == LAST_STG);
  assign iw_done = (run_q == RUN_INT_WIDE) & (stage_q == IW_STG);

  // Next occupancy; single multiply frees the unit after one cycle
  always_comb
  begin
    run_d = run_q;
    if (run_q != RUN_NONE)
    begin
      if (stage_q == LAST_STG)
      begin
        run_d = RUN_NONE;
      end
    end
    else if (accept)
    begin
      unique case (issue_kind_i)
        KIND_FP64: run_d = RUN_FP64;
        KIND_INT:  run_d = opf_wide(issue_opfield_i) ? RUN_INT_WIDE : RUN_INT_LOW;
        default:   run_d = RUN_NONE;
      endcase
    end
  end

  // Occupancy register and stage count
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      run_q   <= RUN_NONE;
      stage_q <= 2'h0;
    end
    else
    begin
      run_q   <= run_d;
      stage_q <= (run_d == RUN_NONE) ? 2'h0 : stage_q + 2'h1;
    end
  end

  // Ready drops for the whole occupancy of a four-stage operation
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      issue_ready_o <= 1'b1;
    end
    else
    begin
      issue_ready_o <= (run_d == RUN_NONE);
    end
  end

  // Operand half selects for E2..E4: (l,h), (h,l), (h,h)
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      src1_hi_o <= 1'b0;
      src2_hi_o <= 1'b0;
    end
    else
    begin
      src1_hi_o <= (run_d == RUN_FP64) & (stage_q != 2'h0 || run_q == RUN_NONE ? stage_q >= 2'h1 : 1'b0);
      src2_hi_o <= (run_d == RUN_FP64) & (stage_q != 2'h1);
    end
  end

  // Low words of double operands and integer fields held over the run
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      a_lo_q <= 32'h0000_0000;
      b_lo_q <= 32'h0000_0000;
      opf_q  <= 5'h00;
      cst_q  <= 5'h00;
    end
    else if (accept)
    begin
      a_lo_q <= src1_i;
      b_lo_q <= src2_i;
      opf_q  <= issue_opfield_i;
      cst_q  <= issue_cst_i;
    end
  end

  // Single and double floating datapaths; high words arrive at E4
  fp_mul_core #(
    .EXP_W (SP_EXP_W),
    .MAN_W (SP_MAN_W)
  ) u_fp32 (
    .a_i     (src1_i),
    .b_i     (src2_i),
    .res_o   (sp_res),
    .flags_o (sp_flags)
  );

  fp_mul_core #(
    .EXP_W (DP_EXP_W),
    .MAN_W (DP_MAN_W)
  ) u_fp64 (
    .a_i     ({src1_i, a_lo_q}),
    .b_i     ({src2_i, b_lo_q}),
    .res_o   (dp_res),
    .flags_o (dp_flags)
  );

  // Integer operands are re-read live; the constant is sign extended
  assign opf_now  = (run_q == RUN_NONE) ? issue_opfield_i : opf_q;
  assign cst_now  = (run_q == RUN_NONE) ? issue_cst_i : cst_q;
  assign int_a    = opf_cst(opf_now) ? {{(DATA_W-5){cst_now[4]}}, cst_now} : src1_i;
  assign int_prod = $signed({{DATA_W{int_a[DATA_W-1]}}, int_a}) *
                    $signed({{DATA_W{src2_i[DATA_W-1]}}, src2_i});

  // Place finished words at the slot matching their write stage
  always_comb
  begin
    ins_v     = '0;
    ins_odd   = '0;
    ins_data  = '{default: '0};
    ins_flags = '{default: '0};
    if (fire_sp)
    begin
      ins_v[SLOT_SP]     = 1'b1;
      ins_data[SLOT_SP]  = sp_res;
      ins_flags[SLOT_SP] = sp_flags;
    end
    if (dp_done)
    begin
      ins_v[SLOT_DP_LO]     = 1'b1;
      ins_data[SLOT_DP_LO]  = dp_res[DATA_W-1:0];
      ins_flags[SLOT_DP_LO] = dp_flags;
      ins_v[SLOT_DP_HI]     = 1'b1;
      ins_odd[SLOT_DP_HI]   = 1'b1;
      ins_data[SLOT_DP_HI]  = dp_res[2*DATA_W-1:DATA_W];
    end
    if (il_done)
    begin
      ins_v[SLOT_IL]    = 1'b1;
      ins_data[SLOT_IL] = int_prod[DATA_W-1:0];
    end
    if (iw_done)
    begin
      ins_v[SLOT_IW_LO]    = 1'b1;
      ins_data[SLOT_IW_LO] = int_prod[DATA_W-1:0];
      ins_v[SLOT_IW_HI]    = 1'b1;
      ins_odd[SLOT_IW_HI]  = 1'b1;
      ins_data[SLOT_IW_HI] = int_prod[2*DATA_W-1:DATA_W];
    end
  end

  // Delay line: a word already in flight keeps its write slot
  for (genvar i = 0; i < LINE_D; i++)
  begin : g_line
    logic              up_v;
    logic              up_odd;
    logic [DATA_W-1:0] up_data;
    logic [FLAG_W-1:0] up_flags;
    if (i == LINE_D - 1)
    begin : g_top
      assign up_v     = 1'b0;
      assign up_odd   = 1'b0;
      assign up_data  = '0;
      assign up_flags = '0;
    end
    else
    begin : g_mid
      assign up_v     = line_v_q[i+1];
      assign up_odd   = line_odd_q[i+1];
      assign up_data  = line_data_q[i+1];
      assign up_flags = line_flags_q[i+1];
    end
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
      if (!rstn_i)
      begin
        line_v_q[i]     <= 1'b0;
        line_odd_q[i]   <= 1'b0;
        line_data_q[i]  <= '0;
        line_flags_q[i] <= '0;
      end
      else if (!up_v && ins_v[i])
      begin
        line_v_q[i]     <= 1'b1;
        line_odd_q[i]   <= ins_odd[i];
        line_data_q[i]  <= ins_data[i];
        line_flags_q[i] <= ins_flags[i];
      end
      else
      begin
        line_v_q[i]     <= up_v;
        line_odd_q[i]   <= up_odd;
        line_data_q[i]  <= up_data;
        line_flags_q[i] <= up_flags;
      end
    end
  end

  // Write port to the register file, low word a cycle before high
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_valid_o <= 1'b0;
      wr_odd_o   <= 1'b0;
      wr_data_o  <= 32'h0000_0000;
      wr_flags_o <= 4'h0;
    end
    else
    begin
      wr_valid_o <= line_v_q[0];
      wr_odd_o   <= line_odd_q[0];
      wr_data_o  <= line_data_q[0];
      wr_flags_o <= line_v_q[0] ? line_flags_q[0] : 4'h0;
    end
  end

  // Sticky flags: a new event wins over a same-cycle clear
  always_comb
  begin
    status_d = status_q;
    mask_d   = mask_q;
    if (reg_wr_i && (reg_addr_i == REG_STATUS))
    begin
      status_d = status_q & ~reg_wdata_i[FLAG_W-1:0];
    end
    if (reg_wr_i && (reg_addr_i == REG_MASK))
    begin
      mask_d = reg_wdata_i[FLAG_W-1:0];
    end
    if (line_v_q[0])
    begin
      status_d = status_d | line_flags_q[0];
    end
  end

  // Status and mask registers
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      status_q <= STATUS_RST;
      mask_q   <= MASK_RST;
    end
    else
    begin
      status_q <= status_d;
      mask_q   <= mask_d;
    end
  end

  // Level interrupt follows the registered status and mask
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(status_d & mask_d);
    end
  end

  // Read data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      reg_rdata_o <= 32'h0000_0000;
    end
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        REG_STATUS: reg_rdata_o <= {28'h0000000, status_q};
        REG_MASK:   reg_rdata_o <= {28'h0000000, mask_q};
        REG_STATE:  reg_rdata_o <= {26'h0000000, stage_q, run_q, issue_ready_o, |line_v_q};
        default:    reg_rdata_o <= 32'h0000_0000;
      endcase
    end
    else
    begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule

// ===== test/mul_unit_checker_asserts.sv
`timescale 1ns/1ps
module mul_unit_checker
  import fmul_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rstn_i,
  // Issue side
  input  wire logic                 issue_valid_i,
  input  wire logic                 issue_cond_i,
  input  wire fmul_pkg::mul_kind_t  issue_kind_i,
  input  wire logic [4:0]           issue_opfield_i,
  input  wire logic                 issue_ready_o,
  // Word selects and write-back
  input  wire logic                 src1_hi_o,
  input  wire logic                 src2_hi_o,
  input  wire logic                 wr_valid_o,
  input  wire logic                 wr_odd_o,
  input  wire logic [fmul_pkg::FLAG_W-1:0] wr_flags_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Accepted issues by kind; a refused one must start nothing
  logic go;
  logic go_sp;
  logic go_dp;
  logic go_il;
  logic go_iw;
  assign go    = issue_valid_i && issue_cond_i && issue_ready_o;
  assign go_sp = go && issue_kind_i == KIND_FP32;
  assign go_dp = go && issue_kind_i == KIND_FP64;
  assign go_il = go && issue_kind_i == KIND_INT && issue_opfield_i inside {OPF_LOW_REG, OPF_LOW_CST};
  assign go_iw = go && issue_kind_i == KIND_INT && issue_opfield_i inside {OPF_WIDE_REG, OPF_WIDE_CST};

  sp_write_a: assert property (go_sp |-> ##3 wr_valid_o && !wr_odd_o)
    else $error("fp32 result not written in E4");
  sp_busy_a: assert property (go_sp |=> issue_ready_o)
    else $error("fp32 held the unit");
  dp_write_a: assert property (go_dp |-> ##8 wr_valid_o && !wr_odd_o ##1 wr_valid_o && wr_odd_o)
    else $error("fp64 words not written in E9 and E10");
  dp_busy_a: assert property (go_dp |=> !issue_ready_o [*3] ##1 issue_ready_o)
    else $error("fp64 occupancy not four cycles");
  dp_select_a: assert property (go_dp |-> !src1_hi_o && !src2_hi_o ##1 !src1_hi_o && src2_hi_o
    ##1 src1_hi_o && !src2_hi_o ##1 src1_hi_o && src2_hi_o)
    else $error("fp64 operand word order wrong");
  int_low_a: assert property (go_il |-> ##8 wr_valid_o && !wr_odd_o && wr_flags_o == 4'h0)
    else $error("low integer product not written in E9");
  int_wide_a: assert property (go_iw |-> ##8 wr_valid_o && !wr_odd_o ##1 wr_valid_o && wr_odd_o)
    else $error("wide integer words not written in E9 and E10");
  nop_idle_a: assert property (issue_valid_i && !issue_cond_i && issue_ready_o |=> issue_ready_o)
    else $error("false predicate occupied the unit");
  odd_flags_a: assert property (wr_valid_o && wr_odd_o |-> wr_flags_o == 4'h0)
    else $error("flags on a high word");

  // Main traffic seen
  cover property (go_sp ##3 wr_valid_o);
  cover property (go_dp);
  cover property (go_iw);
endmodule

bind fp_int_multiply_unit mul_unit_checker i_mul_unit_checker (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .issue_valid_i(issue_valid_i),
  .issue_cond_i(issue_cond_i), .issue_kind_i(issue_kind_i), .issue_opfield_i(issue_opfield_i),
  .issue_ready_o(issue_ready_o), .src1_hi_o(src1_hi_o), .src2_hi_o(src2_hi_o),
  .wr_valid_o(wr_valid_o), .wr_odd_o(wr_odd_o), .wr_flags_o(wr_flags_o)
);

// ===== test/regfile_model.sv
`timescale 1ns/1ps
module regfile_model (
  // Word selects from the unit
  input  wire logic        src1_hi_i,
  input  wire logic        src2_hi_i,
  // Register pairs named by the instruction
  input  wire logic [63:0] op1_i,
  input  wire logic [63:0] op2_i,
  // Read ports
  output logic      [31:0] src1_o,
  output logic      [31:0] src2_o
);
  // Even register low word, odd register high word
  assign src1_o = src1_hi_i ? op1_i[63:32] : op1_i[31:0];
  assign src2_o = src2_hi_i ? op2_i[63:32] : op2_i[31:0];
endmodule

// ===== test/test_fp_int_multiply_unit.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
  $display("BAD %0t got %h want %h", $time, got, exp); end end
module test_fp_int_multiply_unit;
  import fmul_pkg::*;
  // Stimulus
  logic        core_clk_i      = 1'h0;
  logic        rstn_i          = 1'h0;
  logic        issue_valid_i   = 1'h0;
  logic        issue_cond_i    = 1'h0;
  mul_kind_t   issue_kind_i    = KIND_FP32;
  logic [4:0]  issue_opfield_i = 5'h00;
  logic [4:0]  issue_cst_i     = 5'h00;
  logic [3:0]  reg_addr_i      = 4'h0;
  logic [31:0] reg_wdata_i     = 32'h0;
  logic        reg_wr_i        = 1'h0;
  logic        reg_rd_i        = 1'h0;
  logic [63:0] op1             = 64'h0;
  logic [63:0] op2             = 64'h0;
  // Outputs
  wire         issue_ready_o;
  wire  [31:0] src1_i;
  wire  [31:0] src2_i;
  wire         src1_hi_o;
  wire         src2_hi_o;
  wire         wr_valid_o;
  wire         wr_odd_o;
  wire  [31:0] wr_data_o;
  wire  [3:0]  wr_flags_o;
  wire  [31:0] reg_rdata_o;
  wire         irq_o;
  int          err_count   = 0;
  int          comparisons = 0;
  // fp32 cases: a, b, product, flags
  localparam logic [99:0] SPC [11] = '{100'h40000000_40400000_40C00000_0, 100'hFF800001_3F800000_FFFFFFFF_1,
    100'h7FC00000_BF800000_FFFFFFFF_0, 100'h7F800000_80000000_FFFFFFFF_1, 100'h7F800000_C0000000_FF800000_0,
    100'h80000000_40000000_80000000_0, 100'h00000001_40000000_00000000_6, 100'h7F800000_80000001_FFFFFFFF_9,
    100'h3F800001_3F800001_3F800002_2, 100'h00000000_7FC00000_7FFFFFFF_0, 100'hFF800000_FF800000_7F800000_0};

  fp_int_multiply_unit i_fp_int_multiply_unit (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .issue_valid_i(issue_valid_i), .issue_cond_i(issue_cond_i),
    .issue_kind_i(issue_kind_i), .issue_opfield_i(issue_opfield_i), .issue_cst_i(issue_cst_i),
    .issue_ready_o(issue_ready_o), .src1_i(src1_i), .src2_i(src2_i), .src1_hi_o(src1_hi_o),
    .src2_hi_o(src2_hi_o), .wr_valid_o(wr_valid_o), .wr_odd_o(wr_odd_o), .wr_data_o(wr_data_o),
    .wr_flags_o(wr_flags_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
  regfile_model i_regfile_model (
    .src1_hi_i(src1_hi_o), .src2_hi_i(src2_hi_o), .op1_i(op1), .op2_i(op2), .src1_o(src1_i), .src2_o(src2_i));

  // 200 MHz clock
  always #2.5 core_clk_i = ~core_clk_i;

  // One instruction; constant rides in the low bits of op1
  task automatic issue(input mul_kind_t k, input logic [4:0] f, input logic c, input logic [63:0] a, b);
    @(posedge core_clk_i);
    issue_valid_i <= 1'h1;
    issue_kind_i <= k;
    issue_opfield_i <= f;
    issue_cond_i <= c;
    issue_cst_i <= a[4:0];
    op1 <= a;
    op2 <= b;
    @(posedge core_clk_i);
    issue_valid_i <= 1'h0;
  endtask

  // Expect one written word n edges on, sampled after the edge settles
  task automatic see(input int n, input logic o, input logic [31:0] d, input logic [3:0] fl);
    repeat (n) @(posedge core_clk_i);
    #1;
    `CHK(wr_valid_o, 1'h1)
    `CHK(wr_odd_o, o)
    `CHK(wr_data_o, d)
    `CHK(wr_flags_o, fl)
  endtask

  // Register port cycles
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'h0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'h0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic t_fp32();
    foreach (SPC[i])
    begin
      issue(KIND_FP32, 5'h00, 1'h1, {32'h0, SPC[i][99:68]}, {32'h0, SPC[i][67:36]});
      see(2, 1'h0, SPC[i][35:4], SPC[i][3:0]);
    end
    $display("test fp32 done");
  endtask

  // Sticky flags, mask, irq, then false predicates and an illegal field that must stay silent
  task automatic t_regs();
    logic [31:0] d;
    reg_rd(REG_STATUS, d);
    `CHK(d, 32'hF)
    reg_rd(REG_MASK, d);
    `CHK(d, 32'h0)
    `CHK(irq_o, 1'h0)
    reg_wr(REG_MASK, 32'h1);
    @(posedge core_clk_i);
    #1;
    `CHK(irq_o, 1'h1)
    reg_wr(REG_STATUS, 32'hF);
    @(posedge core_clk_i);
    #1;
    `CHK(irq_o, 1'h0)
    reg_rd(4'hC, d);
    `CHK(d, 32'h0)
    reg_rd(REG_STATE, d);
    `CHK(d, 32'h2)
    issue(KIND_FP32, 5'h00, 1'h0, 64'hFF800001, 64'h00000001);
    repeat (2) @(posedge core_clk_i);
    #1;
    `CHK(wr_valid_o, 1'h0)
    issue(KIND_FP64, 5'h00, 1'h0, 64'hFFF00000_00000001, 64'h0);
    #1;
    `CHK(issue_ready_o, 1'h1)
    issue(KIND_INT, 5'h05, 1'h1, 64'h3, 64'h3);
    repeat (7) @(posedge core_clk_i);
    #1;
    `CHK(wr_valid_o, 1'h0)
    reg_rd(REG_STATUS, d);
    `CHK(d, 32'h0)
    $display("test registers done");
  endtask

  task automatic t_fp64();
    issue(KIND_FP64, 5'h00, 1'h1, 64'h3FF80000_00000000, 64'h3FF00000_00000004);
    see(7, 1'h0, 32'h00000006, 4'h0);
    see(1, 1'h1, 32'h3FF80000, 4'h0);
    issue(KIND_FP64, 5'h00, 1'h1, 64'hFFF00000_00000001, 64'h3FF00000_00000000);
    see(7, 1'h0, 32'hFFFFFFFF, 4'h1);
    see(1, 1'h1, 32'hFFFFFFFF, 4'h0);
    $display("test fp64 done");
  endtask

  task automatic t_int();
    issue(KIND_INT, OPF_LOW_REG, 1'h1, 64'h00345678, 64'h00112765);
    see(7, 1'h0, 32'hCBCA6558, 4'h0);
    issue(KIND_INT, OPF_WIDE_REG, 1'h1, 64'h00345678, 64'h00112765);
    see(7, 1'h0, 32'hCBCA6558, 4'h0);
    see(1, 1'h1, 32'h00000381, 4'h0);
    issue(KIND_INT, OPF_LOW_CST, 1'h1, 64'h1F, 64'h5);
    see(7, 1'h0, 32'hFFFFFFFB, 4'h0);
    issue(KIND_INT, OPF_WIDE_CST, 1'h1, 64'h1F, 64'h5);
    see(7, 1'h0, 32'hFFFFFFFB, 4'h0);
    see(1, 1'h1, 32'hFFFFFFFF, 4'h0);
    $display("test integer done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence after a 16-cycle reset
  initial
  begin
    repeat (16) @(posedge core_clk_i);
    rstn_i <= 1'h1;
    #1;
    `CHK(issue_ready_o, 1'h1)
    `CHK(wr_valid_o, 1'h0)
    t_fp32();
    t_regs();
    t_fp64();
    t_int();
    tally_and_finish();
  end

  // Watchdog, far beyond the roughly 150 cycles the tests need
  initial
  begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule
